// file: verilog/lbw_consts.vh
// Register map, field positions, reset values and timing for the LED PWM
`ifndef LBW_CONSTS_VH
`define LBW_CONSTS_VH

// Register byte offsets
`define LBW_CFG_OFS 12'h000
`define LBW_LIMIT_OFS 12'h004
`define LBW_DELAY_OFS 12'h008
`define LBW_HOLD_OFS 12'h00C
`define LBW_STATUS_OFS 12'h010

// Configuration register fields
`define LBW_CFG_CTRL_LSB 0
`define LBW_CFG_CTRL_MSB 1
`define LBW_CFG_SRC_BIT 2
`define LBW_CFG_WDT_LSB 8
`define LBW_CFG_WDT_MSB 15

// Limit register fields (duty in the low byte)
`define LBW_LIM_DUTY_LSB 0
`define LBW_LIM_DUTY_MSB 7
`define LBW_LIM_MAX_LSB 8
`define LBW_LIM_MAX_MSB 15

// Delay register field
`define LBW_DLY_LSB 0
`define LBW_DLY_MSB 11

// Hold register fields (pause at top and bottom brightness)
`define LBW_HOLD_TOP_LSB 0
`define LBW_HOLD_TOP_MSB 7
`define LBW_HOLD_BOT_LSB 8
`define LBW_HOLD_BOT_MSB 15

// Status register fields
`define LBW_ST_WDT_LSB 0
`define LBW_ST_WDT_MSB 7
`define LBW_ST_CNT_LSB 8
`define LBW_ST_CNT_MSB 15
`define LBW_ST_OUT_BIT 16

// Mode control encodings
`define LBW_MODE_OFF 2'h0
`define LBW_MODE_BREATHE 2'h1
`define LBW_MODE_BLINK 2'h2
`define LBW_MODE_ON 2'h3

// Reset values
`define LBW_CTRL_RST 2'h0
`define LBW_SRC_RST 1'b0
`define LBW_WDT_RST 8'h14
`define LBW_DUTY_RST 8'h00
`define LBW_MAX_RST 8'hFF
`define LBW_DLY_RST 12'h000
`define LBW_HOLD_RST 8'h00

// Duty value that keeps the output on for the whole period
`define LBW_DUTY_FULL 8'hFF
// Watchdog time per reload count, milliseconds
`define LBW_WDT_UNIT_MS 200

`endif

// file: verilog/lbw_pwm_core.v
// Delay prescaler, 8-bit period counter and duty comparator
`timescale 1ns/1ps
`default_nettype none

module lbw_pwm_core #(
    parameter DLY_W = 12,
    parameter CNT_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire tick,
    input wire [DLY_W-1:0] reload,
    input wire [CNT_W-1:0] duty,
    output reg [CNT_W-1:0] count,
    output reg level
);
    reg [DLY_W-1:0] delay_cnt;
    wire [CNT_W-1:0] full = {CNT_W{1'b1}};

    // Prescaler: a step every reload+1 ticks, every tick for zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_cnt <= {DLY_W{1'b0}};
            count <= {CNT_W{1'b0}};
        end else if (!run) begin
            delay_cnt <= {DLY_W{1'b0}};
            count <= {CNT_W{1'b0}};
        end else if (tick) begin
            if (delay_cnt == {DLY_W{1'b0}}) begin
                delay_cnt <= reload;
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                delay_cnt <= delay_cnt - {{(DLY_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Compare stage; an all-ones duty holds the level high throughout
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else begin
            level <= run & ((duty == full) | (count < duty));
        end
    end
endmodule

`default_nettype wire

// file: verilog/lbw_top.v
// APB-mapped blinking / general-purpose PWM with watchdog
//
// What this block does
// - Output from 8-bit counter versus duty compare
// - Hardware never changes the programmed duty
// - Counter is plain wrapping 8-bit up count
// - Delay counter prescales slow clock ticks
// - Duty zero off, duty all ones on
// - Prescale from delay field, duty from limits
// - Frequency is clock over reload+1 over 256
// - Blink period spans 7.8 ms to 32 s
// - Main clock source gives general-purpose PWM
// - Main clock rate, prescale up to FFFh
// - Watchdog runs only in general-purpose PWM
// - Watchdog: 8-bit down counter plus reload field
// - Counter and reload reset to 14h
// - Reload on config write or duty byte write
// - Decrement on each 5 Hz tick when non-zero
// - One-to-zero step: event, mode forced full on
// - Missing ticks hold the count
// - Reload zero disables; count is 200 ms
// - Breathing runs from slow clock time base
// - Top and bottom pause fields stored and read back only; output ignores them
// - Output active while count below duty
// - Zero reload passes ticks undivided
// - Timeout event lasts one clock
`timescale 1ns/1ps
`default_nettype none
`include "lbw_consts.vh"

module lbw_top #(
    parameter DLY_W = 12,
    parameter CNT_W = 8,
    parameter WDT_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire slow_clk_in,
    input wire main_clk_in,
    input wire wdt_tick,
    output reg indicator_output,
    output reg pwm_watchdog_event
);
    // Byte-lane merge for register writes
    function [31:0] lbw_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            lbw_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    lbw_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode for the error path; the read mux decodes its own case
    function lbw_mapped;
        input [11:0] addr;
        begin
            lbw_mapped = (addr == `LBW_CFG_OFS) ||
                (addr == `LBW_LIMIT_OFS) ||
                (addr == `LBW_DELAY_OFS) ||
                (addr == `LBW_HOLD_OFS) ||
                (addr == `LBW_STATUS_OFS);
        end
    endfunction

    // Software-visible state
    reg [1:0] mode_ctrl;
    reg clock_source;
    reg [WDT_W-1:0] watchdog_reload_value;
    reg [CNT_W-1:0] duty_value;
    reg [CNT_W-1:0] max_value;
    reg [DLY_W-1:0] divider_reload;
    reg [7:0] hold_top;
    reg [7:0] hold_bottom;
    reg [WDT_W-1:0] wdt_count;

    // Clock-input synchronisers and edge detection
    reg slow_s1;
    reg slow_s2;
    reg slow_s3;
    reg main_s1;
    reg main_s2;
    reg main_s3;
    wire slow_tick;
    wire main_tick;

    // Bus phase decode
    wire setup_phase;
    wire wr_access;
    wire [31:0] cfg_image;
    wire [31:0] lim_image;
    wire [31:0] dly_image;
    wire [31:0] hold_image;
    wire [31:0] status_image;
    wire [31:0] cfg_new;
    wire [31:0] lim_new;
    wire [31:0] dly_new;
    wire [31:0] hold_new;
    wire cfg_wr;
    wire lim_wr;
    wire dly_wr;
    wire hold_wr;
    wire wdt_reload_now;

    // Mode decode and PWM core hookup
    wire gp_mode;
    wire core_run;
    wire core_tick;
    wire [CNT_W-1:0] core_count;
    wire core_level;
    wire wdt_timeout;
    reg [31:0] next_prdata;

    // Two flops on each pin before any logic reads it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
            main_s1 <= 1'b0;
            main_s2 <= 1'b0;
            main_s3 <= 1'b0;
        end else begin
            slow_s1 <= slow_clk_in;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
            main_s1 <= main_clk_in;
            main_s2 <= main_s1;
            main_s3 <= main_s2;
        end
    end

    // One-cycle strobes on rising edges of the sampled clocks
    assign slow_tick = slow_s2 & ~slow_s3;
    assign main_tick = main_s2 & ~main_s3;

    // Source and mode selection
    assign gp_mode = (mode_ctrl == `LBW_MODE_BLINK) & clock_source;
    assign core_tick = gp_mode ? main_tick : slow_tick;
    assign core_run = (mode_ctrl == `LBW_MODE_BLINK) |
        (mode_ctrl == `LBW_MODE_BREATHE);

    // Prescaler and counter; the duty input is only read here
    lbw_pwm_core #(
        .DLY_W(DLY_W),
        .CNT_W(CNT_W)
    ) u_core (
        .clk(pclk),
        .rst_n(presetn),
        .run(core_run),
        .tick(core_tick),
        .reload(divider_reload),
        .duty(duty_value),
        .count(core_count),
        .level(core_level)
    );

    // APB: zero wait states, error only on unmapped addresses
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~lbw_mapped(paddr);
    assign setup_phase = psel & ~penable;
    assign wr_access = psel & penable & pwrite;

    // Register images as software sees them
    assign cfg_image = {16'h0000, watchdog_reload_value, 5'h00,
        clock_source, mode_ctrl};
    assign lim_image = {16'h0000, max_value, duty_value};
    assign dly_image = {20'h0_0000, divider_reload};
    assign hold_image = {16'h0000, hold_bottom, hold_top};
    assign status_image = {15'h0000, indicator_output, core_count,
        wdt_count};

    // Merged write data per register
    assign cfg_new = lbw_merge(cfg_image, pwdata, pstrb);
    assign lim_new = lbw_merge(lim_image, pwdata, pstrb);
    assign dly_new = lbw_merge(dly_image, pwdata, pstrb);
    assign hold_new = lbw_merge(hold_image, pwdata, pstrb);

    // Write strobes, taken in the access phase
    assign cfg_wr = wr_access & (paddr == `LBW_CFG_OFS);
    assign lim_wr = wr_access & (paddr == `LBW_LIMIT_OFS);
    assign dly_wr = wr_access & (paddr == `LBW_DELAY_OFS);
    assign hold_wr = wr_access & (paddr == `LBW_HOLD_OFS);
    assign wdt_reload_now = cfg_wr | (lim_wr & pstrb[0]);

    // Configuration register; a config write in the same cycle blocks the watchdog trip
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl <= `LBW_CTRL_RST;
            clock_source <= `LBW_SRC_RST;
            watchdog_reload_value <= `LBW_WDT_RST;
        end else begin
            if (cfg_wr) begin
                mode_ctrl <= cfg_new[`LBW_CFG_CTRL_MSB:`LBW_CFG_CTRL_LSB];
                clock_source <= cfg_new[`LBW_CFG_SRC_BIT];
                watchdog_reload_value <=
                    cfg_new[`LBW_CFG_WDT_MSB:`LBW_CFG_WDT_LSB];
            end
            if (wdt_timeout) begin
                mode_ctrl <= `LBW_MODE_ON;
            end
        end
    end

    // Limit register; duty is never changed by hardware
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_value <= `LBW_DUTY_RST;
            max_value <= `LBW_MAX_RST;
        end else if (lim_wr) begin
            duty_value <= lim_new[`LBW_LIM_DUTY_MSB:`LBW_LIM_DUTY_LSB];
            max_value <= lim_new[`LBW_LIM_MAX_MSB:`LBW_LIM_MAX_LSB];
        end
    end

    // Delay register, up to FFFh prescale
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_reload <= `LBW_DLY_RST;
        end else if (dly_wr) begin
            divider_reload <= dly_new[`LBW_DLY_MSB:`LBW_DLY_LSB];
        end
    end

    // Hold register: top and bottom pause fields, stored and read back only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_top <= `LBW_HOLD_RST;
            hold_bottom <= `LBW_HOLD_RST;
        end else if (hold_wr) begin
            hold_top <= hold_new[`LBW_HOLD_TOP_MSB:`LBW_HOLD_TOP_LSB];
            hold_bottom <= hold_new[`LBW_HOLD_BOT_MSB:`LBW_HOLD_BOT_LSB];
        end
    end

    // Watchdog trips on the step from one to zero in PWM mode only
    assign wdt_timeout = gp_mode & wdt_tick & ~wdt_reload_now &
        (wdt_count == {{(WDT_W-1){1'b0}}, 1'b1});

    // Watchdog down counter; a reload takes priority over a tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_count <= `LBW_WDT_RST;
        end else if (wdt_reload_now) begin
            wdt_count <= cfg_wr ?
                cfg_new[`LBW_CFG_WDT_MSB:`LBW_CFG_WDT_LSB] :
                watchdog_reload_value;
        end else if (gp_mode & wdt_tick &
            (wdt_count != {WDT_W{1'b0}})) begin
            wdt_count <= wdt_count - {{(WDT_W-1){1'b0}}, 1'b1};
        end
    end

    // Timeout event: a single-clock pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_watchdog_event <= 1'b0;
        end else begin
            pwm_watchdog_event <= wdt_timeout;
        end
    end

    // Output pin: off, counter compare, or forced on
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indicator_output <= 1'b0;
        end else begin
            case (mode_ctrl)
                `LBW_MODE_OFF: begin
                    indicator_output <= 1'b0;
                end
                `LBW_MODE_BREATHE: begin
                    indicator_output <= core_level;
                end
                `LBW_MODE_BLINK: begin
                    indicator_output <= core_level;
                end
                `LBW_MODE_ON: begin
                    indicator_output <= 1'b1;
                end
                default: begin
                    indicator_output <= 1'b0;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `LBW_CFG_OFS: begin
                next_prdata = cfg_image;
            end
            `LBW_LIMIT_OFS: begin
                next_prdata = lim_image;
            end
            `LBW_DELAY_OFS: begin
                next_prdata = dly_image;
            end
            `LBW_HOLD_OFS: begin
                next_prdata = hold_image;
            end
            `LBW_STATUS_OFS: begin
                next_prdata = status_image;
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured in the setup phase, stable through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
        end
    end
endmodule

`default_nettype wire

// file: test/lbw_led_model.sv
// Indicator load model counting lit cycles
`timescale 1ns/1ps
`default_nettype none
module lbw_led_model (
    input wire logic pclk,
    input wire logic clear,
    input wire logic level,
    output logic [15:0] on_cycles
);
    // Lit time grows while the drive is high
    always @(posedge pclk) begin
        if (clear)
            on_cycles <= 16'h0000;
        else if (level === 1'b1)
            on_cycles <= on_cycles + 16'h0001;
    end
endmodule
`default_nettype wire

// file: test/lbw_checker.sv
// Port checker for the LED PWM block
`timescale 1ns/1ps
`default_nettype none
module lbw_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire slow_clk_in,
    input wire main_clk_in,
    input wire wdt_tick,
    input wire indicator_output,
    input wire pwm_watchdog_event
);
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire mapped = paddr <= 12'h010 && paddr[1:0] == 2'b00;
    reg [3:0] quiet;
    reg [1:0] pins_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last cause that may move the output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet <= 4'h0;
            pins_q <= 2'b00;
        end else begin
            pins_q <= {slow_clk_in, main_clk_in};
            if (wr || pwm_watchdog_event ||
                pins_q != {slow_clk_in, main_clk_in})
                quiet <= 4'h0;
            else if (quiet != 4'hf)
                quiet <= quiet + 4'h1;
        end
    end
    sequence s_evt_out;
        ##1 indicator_output;
    endsequence
    property p_evt_pulse;
        pwm_watchdog_event |=> !pwm_watchdog_event;
    endproperty
    a_evt_pulse: assert property (p_evt_pulse)
        else $error("timeout event wider than one cycle");
    property p_evt_cause;
        pwm_watchdog_event |-> $past(wdt_tick);
    endproperty
    a_evt_cause: assert property (p_evt_cause)
        else $error("timeout event without a tick");
    property p_evt_reload;
        pwm_watchdog_event |-> !$past(wr && paddr == 12'h000);
    endproperty
    a_evt_reload: assert property (p_evt_reload)
        else $error("timeout despite reload");
    property p_evt_out;
        pwm_watchdog_event && !wr |-> s_evt_out;
    endproperty
    a_evt_out: assert property (p_evt_out)
        else $error("output not forced on after timeout");
    property p_quiet;
        quiet >= 4'h8 |-> $stable(indicator_output);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("output moved without a cause");
    property p_err_map;
        pslverr == (acc && !mapped);
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error response mismatch");
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state inserted");
    property p_rd_hold;
        !$past(psel && !penable && !pwrite) |-> $stable(prdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed outside a read");
endmodule
bind lbw_top lbw_checker i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .prdata, .pslverr, .slow_clk_in, .main_clk_in, .wdt_tick,
    .indicator_output, .pwm_watchdog_event
);
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the LED PWM block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic slow_clk_in = 1'b0;
    logic main_clk_in = 1'b0;
    logic wdt_tick = 1'b0;
    logic led_clr = 1'b1;
    wire pready, pslverr, indicator_output, pwm_watchdog_event;
    wire [31:0] prdata;
    wire [15:0] on_cycles;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int ev_cnt = 0;
    logic [31:0] rd;
    logic rerr;
    logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [31:0] rv [5] = '{32'h0000_1400, 32'h0000_ff00, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0014};
    lbw_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .slow_clk_in,
        .main_clk_in, .wdt_tick, .indicator_output, .pwm_watchdog_event);
    lbw_led_model i_led (.pclk, .clear(led_clr),
        .level(indicator_output), .on_cycles);
    // Clock generation
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // Event width counter and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (pwm_watchdog_event === 1'b1)
            ev_cnt++;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    // One period of the slow or main clock pin
    task automatic pin_tick(input logic m);
        if (m)
            main_clk_in <= 1'b1;
        else
            slow_clk_in <= 1'b1;
        repeat (4) @(posedge pclk);
        main_clk_in <= 1'b0;
        slow_clk_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wdt_pulse();
        wdt_tick <= 1'b1;
        @(posedge pclk);
        wdt_tick <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_blink(input logic [7:0] duty);
        logic [7:0] k;
        bus(1'b1, 12'h004, {16'h0000, 8'hff, duty});
        led_clr <= 1'b1;
        bus(1'b1, 12'h000, 32'h0000_1400);
        led_clr <= 1'b0;
        bus(1'b1, 12'h000, 32'h0000_1402);
        for (int i = 1; i <= 256; i++) begin
            wdt_pulse();
            pin_tick(1'b0);
            k = i[7:0];
            chk_rd(12'h010, {15'h0000, duty == 8'hff || k < duty, k,
                8'h14});
        end
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b1, 12'h010, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            chk_rd(ra[i], rv[i]);
        end
        bus(1'b1, 12'h014, 32'hffff_ffff);
        `CHK(rerr, 1'b1)
        chk_rd(12'h014, 32'h0000_0000);
        `CHK(rerr, 1'b1)
        bus(1'b1, 12'h00c, 32'h0000_a55a);
        chk_rd(12'h00c, 32'h0000_a55a);
        `CHK(rerr, 1'b0)
        // Full-width config write: 8-bit reload loads the counter
        bus(1'b1, 12'h000, 32'hffff_ffff);
        chk_rd(12'h000, 32'h0000_ff07);
        chk_rd(12'h010, 32'h0001_00ff);
        run_blink(8'h80);
        run_blink(8'hff);
        run_blink(8'h00);
        `CHK(on_cycles, 16'h0000)
        // Prescale field is twelve bits wide
        bus(1'b1, 12'h008, 32'hffff_ffff);
        chk_rd(12'h008, 32'h0000_0fff);
        // Prescaled counting from the slow pin
        bus(1'b1, 12'h008, 32'h0000_0002);
        bus(1'b1, 12'h000, 32'h0000_1400);
        bus(1'b1, 12'h000, 32'h0000_1402);
        for (int i = 1; i <= 7; i++) begin
            pin_tick(1'b0);
            chk_rd(12'h010, {16'h0000, 8'((i + 2) / 3), 8'h14});
        end
        chk_rd(12'h008, 32'h0000_0002);
        chk_rd(12'h004, 32'h0000_ff00);
        bus(1'b1, 12'h000, 32'h0000_1403);
        chk_rd(12'h010, 32'h0001_0014);
        bus(1'b1, 12'h008, 32'h0000_0000);
        // Breathing counts slow ticks only, whatever the source bit
        bus(1'b1, 12'h000, 32'h0000_1405);
        pin_tick(1'b1);
        pin_tick(1'b0);
        wdt_pulse();
        chk_rd(12'h010, 32'h0000_0114);
        bus(1'b1, 12'h000, 32'h0000_1400);
        // General-purpose mode with watchdog reload of two
        bus(1'b1, 12'h000, 32'h0000_0206);
        pin_tick(1'b1);
        pin_tick(1'b0);
        pin_tick(1'b1);
        chk_rd(12'h010, 32'h0000_0202);
        wdt_pulse();
        chk_rd(12'h010, 32'h0000_0201);
        repeat (40) @(posedge pclk);
        chk_rd(12'h010, 32'h0000_0201);
        // A limit write without the duty lane must not reload
        pstrb <= 4'h2;
        bus(1'b1, 12'h004, 32'h0000_7f55);
        pstrb <= 4'hf;
        chk_rd(12'h004, 32'h0000_7f00);
        chk_rd(12'h010, 32'h0000_0201);
        bus(1'b1, 12'h004, 32'h0000_ff00);
        chk_rd(12'h010, 32'h0000_0202);
        ev_cnt = 0;
        wdt_pulse();
        wdt_pulse();
        repeat (2) @(posedge pclk);
        `CHK(ev_cnt, 1)
        chk_rd(12'h000, 32'h0000_0207);
        chk_rd(12'h010, 32'h0001_0000);
        wdt_pulse();
        `CHK(ev_cnt, 1)
        chk_rd(12'h010, 32'h0001_0000);
        bus(1'b1, 12'h000, 32'h0000_0006);
        wdt_pulse();
        chk_rd(12'h000, 32'h0000_0006);
        `CHK(ev_cnt, 1)
        stop_test();
    end
endmodule
`default_nettype wire
